/* File: hw/cds_pkg.sv */
// constants, field layouts and carrier types for the cpu slowdown and module gating block
package cds_pkg;

  // register port geometry
  localparam int CDS_ADDR_W = 4;
  localparam int CDS_DATA_W = 16;

  // peripheral modules under control
  localparam int CDS_NMOD = 5;
  localparam int CDS_MOD_TIMER = 0;
  localparam int CDS_MOD_SERIAL = 1;
  localparam int CDS_MOD_CAPTURE = 2;
  localparam int CDS_MOD_COMPARE = 3;
  localparam int CDS_MOD_CALENDAR = 4;
  // capture, compare and calendar have no function enable bit
  localparam logic [CDS_NMOD-1:0] CDS_HAS_FEN = 5'h03;

  // register offsets (word index on the plain port)
  localparam logic [CDS_ADDR_W-1:0] CDS_ADR_CLOCK_DIVIDER_CONTROL = 4'h0;
  localparam logic [CDS_ADDR_W-1:0] CDS_ADR_PERIPHERAL_MODULE_DISABLE = 4'h1;
  localparam logic [CDS_ADDR_W-1:0] CDS_ADR_FUNCTION_ENABLE = 4'h2;
  localparam logic [CDS_ADDR_W-1:0] CDS_ADR_STOP_IN_IDLE = 4'h3;
  localparam logic [CDS_ADDR_W-1:0] CDS_ADR_STATUS = 4'h4;

  // clock_divider_control field positions
  localparam int CDS_BIT_RECOVER_ON_INTERRUPT = 15;
  localparam int CDS_RATIO_MSB = 14;
  localparam int CDS_RATIO_LSB = 12;
  localparam int CDS_BIT_SLOWDOWN_ENABLE = 11;

  // status field positions
  localparam int CDS_STAT_IDLE = 0;
  localparam int CDS_STAT_ACTIVE = 1;
  localparam int CDS_STAT_RATIO_LSB = 8;

  // reset values
  localparam logic [2:0] CDS_RATIO_RST = 3'h0;
  localparam logic [CDS_NMOD-1:0] CDS_MOD_RST = 5'h00;
  localparam logic [7:0] CDS_CNT_ZERO = 8'h00;
  localparam logic [CDS_DATA_W-1:0] CDS_DATA_ZERO = 16'h0000;

  // divider reload (ratio minus one) for settings 7 down to 0: 1:256 .. 1:1
  localparam logic [7:0][7:0] CDS_RELOAD_TAB = {8'hFF, 8'h3F, 8'h1F, 8'h0F, 8'h07, 8'h03, 8'h01, 8'h00};

  // clock_divider_control contents
  typedef struct packed {
    logic recover_on_interrupt;
    logic [2:0] ratio;
    logic en;
  } cds_clock_divider_control_s;

  localparam cds_clock_divider_control_s CDS_CLOCK_DIVIDER_CONTROL_RST = '{recover_on_interrupt: 1'b0, ratio: CDS_RATIO_RST, en: 1'b0};

  // cpu execution state
  typedef enum logic [1:0] {
    CDS_ST_RUN = 2'b01,
    CDS_ST_IDLE = 2'b10
  } cds_state_e;

endpackage

/* File: hw/cds_top.sv */
// cpu slowdown clock divider with per-module clock gating, function enable and stop-in-idle
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/10ps

// Operation
// - setting cpu_slowdown_enable (bit 11) turns on slowed cpu clocking
// - cpu_slowdown_ratio bits 14:12 select the peripheral to cpu clock ratio
// - eight ratios from 1:1 to 1:256; 1:1 after reset
// - system clock keeps running unchanged; only the cpu clock is divided
// - peripherals keep full-rate clocking while the cpu is slowed
// - divided cpu clock stays phase-locked to the peripheral clock
// - with recover_on_interrupt (bit 15) set, an interrupt restores full cpu speed
// - with recover_on_interrupt clear, interrupts leave slowdown settings untouched
// - module_clock_gate removes every clock from that module
// - a gated module ignores register writes; its reads are undefined
// - clearing module_function_enable halts the module but keeps registers accessible
// - capture, compare and calendar modules have no function enable
// - module_stop_in_idle set halts the module on entering idle
// - with stop-in-idle clear, modules keep working during idle
// - idle stops cpu execution while the system clock keeps running
module cds_top (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [cds_pkg::CDS_ADDR_W-1:0] reg_addr_i,
  input wire logic [cds_pkg::CDS_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [cds_pkg::CDS_DATA_W-1:0] reg_rdata_o,
  // cpu events, same clock domain
  input wire logic idle_req_i,
  input wire logic irq_i,
  // clock enables and module controls
  output logic cpu_clk_en_o,
  output logic [cds_pkg::CDS_NMOD-1:0] periph_clk_en_o,
  output logic [cds_pkg::CDS_NMOD-1:0] mod_reg_access_o,
  output logic [cds_pkg::CDS_NMOD-1:0] mod_run_o,
  output logic cpu_idle_o
);

  // software-visible configuration
  cds_pkg::cds_clock_divider_control_s clock_divider_control_r;
  cds_pkg::cds_clock_divider_control_s clock_divider_control_nxt;
  logic [cds_pkg::CDS_NMOD-1:0] gate_r;
  logic [cds_pkg::CDS_NMOD-1:0] gate_nxt;
  logic [cds_pkg::CDS_NMOD-1:0] fen_r;
  logic [cds_pkg::CDS_NMOD-1:0] fen_nxt;
  logic [cds_pkg::CDS_NMOD-1:0] sidl_r;
  logic [cds_pkg::CDS_NMOD-1:0] sidl_nxt;
  logic [cds_pkg::CDS_DATA_W-1:0] rdata_r;
  logic [cds_pkg::CDS_DATA_W-1:0] rdata_nxt;

  // divider and execution state
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic act_en_r;
  logic act_en_nxt;
  logic [2:0] act_ratio_r;
  logic [2:0] act_ratio_nxt;
  logic cpu_en_r;
  logic cpu_en_nxt;
  cds_pkg::cds_state_e st_r;
  cds_pkg::cds_state_e st_nxt;
  logic idle_r;
  logic idle_nxt;

  // module-side outputs
  logic [cds_pkg::CDS_NMOD-1:0] pclk_r;
  logic [cds_pkg::CDS_NMOD-1:0] pclk_nxt;
  logic [cds_pkg::CDS_NMOD-1:0] acc_r;
  logic [cds_pkg::CDS_NMOD-1:0] acc_nxt;
  logic [cds_pkg::CDS_NMOD-1:0] run_r;
  logic [cds_pkg::CDS_NMOD-1:0] run_nxt;

  logic boundary;
  logic [cds_pkg::CDS_DATA_W-1:0] status_w;

  // a period boundary is the cycle the divider count sits at zero
  assign boundary = (cnt_r == cds_pkg::CDS_CNT_ZERO);

  // status word shows the settings actually in force, not the requested ones
  always_comb begin
    status_w = cds_pkg::CDS_DATA_ZERO;
    status_w[cds_pkg::CDS_STAT_IDLE] = (st_r == cds_pkg::CDS_ST_IDLE);
    status_w[cds_pkg::CDS_STAT_ACTIVE] = act_en_r;
    status_w[cds_pkg::CDS_STAT_RATIO_LSB +: 3] = act_ratio_r;
  end

  // register writes and reads
  always_comb begin
    clock_divider_control_nxt = clock_divider_control_r;
    gate_nxt = gate_r;
    fen_nxt = fen_r;
    sidl_nxt = sidl_r;
    rdata_nxt = cds_pkg::CDS_DATA_ZERO;
    if (reg_wr_i) begin
      case (reg_addr_i)
        cds_pkg::CDS_ADR_CLOCK_DIVIDER_CONTROL: begin
          clock_divider_control_nxt.en = reg_wdata_i[cds_pkg::CDS_BIT_SLOWDOWN_ENABLE];
          clock_divider_control_nxt.ratio = reg_wdata_i[cds_pkg::CDS_RATIO_MSB:cds_pkg::CDS_RATIO_LSB];
          clock_divider_control_nxt.recover_on_interrupt = reg_wdata_i[cds_pkg::CDS_BIT_RECOVER_ON_INTERRUPT];
        end
        cds_pkg::CDS_ADR_PERIPHERAL_MODULE_DISABLE: begin
          gate_nxt = reg_wdata_i[cds_pkg::CDS_NMOD-1:0];
        end
        cds_pkg::CDS_ADR_FUNCTION_ENABLE: begin
          // no enable bit for capture, compare, calendar
          fen_nxt = reg_wdata_i[cds_pkg::CDS_NMOD-1:0] & cds_pkg::CDS_HAS_FEN;
        end
        cds_pkg::CDS_ADR_STOP_IN_IDLE: begin
          sidl_nxt = reg_wdata_i[cds_pkg::CDS_NMOD-1:0];
        end
        default: begin
          clock_divider_control_nxt = clock_divider_control_r;
        end
      endcase
    end
    // interrupt drops slowdown; it wins over a same-cycle write
    // without recover_on_interrupt the settings are left alone
    if (irq_i && clock_divider_control_r.recover_on_interrupt) begin
      clock_divider_control_nxt.en = 1'b0;
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        cds_pkg::CDS_ADR_CLOCK_DIVIDER_CONTROL: begin
          rdata_nxt[cds_pkg::CDS_BIT_RECOVER_ON_INTERRUPT] = clock_divider_control_r.recover_on_interrupt;
          rdata_nxt[cds_pkg::CDS_RATIO_MSB:cds_pkg::CDS_RATIO_LSB] = clock_divider_control_r.ratio;
          rdata_nxt[cds_pkg::CDS_BIT_SLOWDOWN_ENABLE] = clock_divider_control_r.en;
        end
        cds_pkg::CDS_ADR_PERIPHERAL_MODULE_DISABLE: begin
          rdata_nxt[cds_pkg::CDS_NMOD-1:0] = gate_r;
        end
        cds_pkg::CDS_ADR_FUNCTION_ENABLE: begin
          rdata_nxt[cds_pkg::CDS_NMOD-1:0] = fen_r;
        end
        cds_pkg::CDS_ADR_STOP_IN_IDLE: begin
          rdata_nxt[cds_pkg::CDS_NMOD-1:0] = sidl_r;
        end
        cds_pkg::CDS_ADR_STATUS: begin
          rdata_nxt = status_w;
        end
        default: begin
          rdata_nxt = cds_pkg::CDS_DATA_ZERO;
        end
      endcase
    end
  end

  // configuration registers; ratio resets to 1:1
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clock_divider_control_r <= cds_pkg::CDS_CLOCK_DIVIDER_CONTROL_RST;
      gate_r <= cds_pkg::CDS_MOD_RST;
      fen_r <= cds_pkg::CDS_MOD_RST;
      sidl_r <= cds_pkg::CDS_MOD_RST;
      rdata_r <= cds_pkg::CDS_DATA_ZERO;
    end else begin
      clock_divider_control_r <= clock_divider_control_nxt;
      gate_r <= gate_nxt;
      fen_r <= fen_nxt;
      sidl_r <= sidl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // idle entry on request, wake on any interrupt
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      cds_pkg::CDS_ST_RUN: begin
        if (idle_req_i && !irq_i) begin
          st_nxt = cds_pkg::CDS_ST_IDLE;
        end
      end
      cds_pkg::CDS_ST_IDLE: begin
        if (irq_i) begin
          st_nxt = cds_pkg::CDS_ST_RUN;
        end
      end
      default: begin
        st_nxt = cds_pkg::CDS_ST_RUN;
      end
    endcase
  end

  // divider: the count runs off the system clock, which is never touched,
  // so the cpu enable is always aligned to a peripheral clock edge
  always_comb begin
    cnt_nxt = cnt_r - 8'h01;
    act_en_nxt = act_en_r;
    act_ratio_nxt = act_ratio_r;
    if (boundary) begin
      // settings sampled only at a period boundary
      act_en_nxt = clock_divider_control_r.en;
      act_ratio_nxt = clock_divider_control_r.ratio;
      // ratio table; slowdown off means 1:1
      cnt_nxt = clock_divider_control_r.en ? cds_pkg::CDS_RELOAD_TAB[clock_divider_control_r.ratio] : cds_pkg::CDS_CNT_ZERO;
    end
    // cpu enable fires on system clock edges only
    cpu_en_nxt = boundary && (st_nxt == cds_pkg::CDS_ST_RUN);
    // idle flag kept in its own flop so the pin is not a decode of the state
    idle_nxt = (st_nxt == cds_pkg::CDS_ST_IDLE);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= cds_pkg::CDS_CNT_ZERO;
      act_en_r <= 1'b0;
      act_ratio_r <= cds_pkg::CDS_RATIO_RST;
      cpu_en_r <= 1'b0;
      st_r <= cds_pkg::CDS_ST_RUN;
      idle_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      act_en_r <= act_en_nxt;
      act_ratio_r <= act_ratio_nxt;
      cpu_en_r <= cpu_en_nxt;
      st_r <= st_nxt;
      idle_r <= idle_nxt;
    end
  end

  // per-module clock, register access and run controls
  generate
    for (genvar m = 0; m < cds_pkg::CDS_NMOD; m++) begin : g_mod
      always_comb begin
        // full-rate clock unless gated; slowdown never reaches here
        pclk_nxt[m] = !gate_nxt[m];
        acc_nxt[m] = !gate_nxt[m];
        // run needs clock, enable where present, and idle permission
        run_nxt[m] = !gate_nxt[m] && (fen_nxt[m] || !cds_pkg::CDS_HAS_FEN[m])
                     && !(sidl_nxt[m] && st_nxt == cds_pkg::CDS_ST_IDLE);
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pclk_r <= ~cds_pkg::CDS_MOD_RST;
      acc_r <= ~cds_pkg::CDS_MOD_RST;
      run_r <= ~cds_pkg::CDS_HAS_FEN;
    end else begin
      pclk_r <= pclk_nxt;
      acc_r <= acc_nxt;
      run_r <= run_nxt;
    end
  end

  // outputs straight from flops
  assign reg_rdata_o = rdata_r;
  assign cpu_clk_en_o = cpu_en_r;
  assign periph_clk_en_o = pclk_r;
  assign mod_reg_access_o = acc_r;
  assign mod_run_o = run_r;
  assign cpu_idle_o = idle_r;

  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_full_speed;
    (!act_en_r && st_r == cds_pkg::CDS_ST_RUN && !idle_req_i) |=> cpu_clk_en_o;
  endproperty
  a_full_speed: assert property (p_full_speed) else $error("cpu clock missing at 1:1");

  property p_div_two;
    (cpu_clk_en_o && act_en_r && act_ratio_r == 3'h1) |-> ##1 !cpu_clk_en_o;
  endproperty
  a_div_two: assert property (p_div_two) else $error("1:2 ratio gave back-to-back cpu enables");

  property p_enable_takes;
    (boundary && clock_divider_control_r.en) |=> act_en_r;
  endproperty
  a_enable_takes: assert property (p_enable_takes) else $error("slowdown enable not applied");

  property p_periph_full;
    ##1 (periph_clk_en_o == ~gate_r) && (mod_reg_access_o == ~gate_r);
  endproperty
  a_periph_full: assert property (p_periph_full) else $error("peripheral clock not following gate");

  property p_roi;
    (irq_i && clock_divider_control_r.recover_on_interrupt) |=> !clock_divider_control_r.en;
  endproperty
  a_roi: assert property (p_roi) else $error("interrupt did not drop slowdown");

  property p_no_roi;
    (irq_i && !clock_divider_control_r.recover_on_interrupt && !reg_wr_i) |=> $stable(clock_divider_control_r);
  endproperty
  a_no_roi: assert property (p_no_roi) else $error("interrupt changed slowdown settings");

  property p_no_fen;
    (fen_r & ~cds_pkg::CDS_HAS_FEN) == cds_pkg::CDS_MOD_RST;
  endproperty
  a_no_fen: assert property (p_no_fen) else $error("enable bit on module without one");

  property p_stop_idle;
    (st_r == cds_pkg::CDS_ST_IDLE) |-> ((mod_run_o & sidl_r) == cds_pkg::CDS_MOD_RST);
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("module runs in idle despite stop bit");

  property p_idle_halt;
    (st_r == cds_pkg::CDS_ST_IDLE && !irq_i) |=> !cpu_clk_en_o;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("cpu clocked in idle");

  property p_boundary_only;
    !boundary |=> $stable(act_en_r) && $stable(act_ratio_r);
  endproperty
  a_boundary_only: assert property (p_boundary_only) else $error("ratio changed mid-period");

  property p_gate_halt;
    (mod_run_o & gate_r) == cds_pkg::CDS_MOD_RST;
  endproperty
  a_gate_halt: assert property (p_gate_halt) else $error("gated module still running");

  property p_fen_halt;
    (mod_run_o & ~fen_r & cds_pkg::CDS_HAS_FEN) == cds_pkg::CDS_MOD_RST;
  endproperty
  a_fen_halt: assert property (p_fen_halt) else $error("module runs with its enable clear");

  // a clocked, enabled module without its stop bit must never be halted
  property p_idle_keep;
    (~sidl_r & ~gate_r & (fen_r | ~cds_pkg::CDS_HAS_FEN) & ~mod_run_o) == cds_pkg::CDS_MOD_RST;
  endproperty
  a_idle_keep: assert property (p_idle_keep) else $error("module halted without stop bit");

  property p_idle_entry;
    (st_r == cds_pkg::CDS_ST_RUN && idle_req_i && !irq_i) |=> cpu_idle_o;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle request not taken");

  property p_idle_wake;
    (st_r == cds_pkg::CDS_ST_IDLE && irq_i) |=> !cpu_idle_o;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("interrupt did not end idle");

  c_gated_idle: cover property (st_r == cds_pkg::CDS_ST_IDLE && gate_r != cds_pkg::CDS_MOD_RST);
  c_stop_idle: cover property (st_r == cds_pkg::CDS_ST_IDLE && sidl_r != cds_pkg::CDS_MOD_RST);

  c_slow_max: cover property (act_en_r && act_ratio_r == 3'h7 && cpu_clk_en_o);
  c_idle: cover property (st_r == cds_pkg::CDS_ST_RUN ##1 st_r == cds_pkg::CDS_ST_IDLE);
  c_recover: cover property (irq_i && clock_divider_control_r.recover_on_interrupt && clock_divider_control_r.en);

endmodule // cds_top

/* File: verif/cds_cpu_model.sv */
// cpu core and peripheral model that counts the clock ticks it is handed
`timescale 1ns/10ps
module cds_cpu_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // enables from the block
  input wire logic cpu_clk_en_i,
  input wire logic [cds_pkg::CDS_NMOD-1:0] periph_clk_en_i,
  input wire logic [cds_pkg::CDS_NMOD-1:0] mod_run_i,
  // observed activity
  output logic [15:0] cpu_ticks_o,
  output logic [cds_pkg::CDS_NMOD-1:0][15:0] run_ticks_o
);
  // the core executes only on an enabled edge; a module works only when clocked and allowed
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_ticks_o <= 16'h0000;
      run_ticks_o <= '0;
    end else begin
      if (cpu_clk_en_i) cpu_ticks_o <= cpu_ticks_o + 16'h0001;
      for (int m = 0; m < cds_pkg::CDS_NMOD; m++) begin
        if (periph_clk_en_i[m] && mod_run_i[m]) run_ticks_o[m] <= run_ticks_o[m] + 16'h0001;
      end
    end
  end
endmodule // cds_cpu_model

/* File: verif/testbench.sv */
// self-checking bench for the cpu slowdown and module gating block
`timescale 1ns/10ps
module testbench;
  logic ref_clk_i, rst_i, reg_wr_i, reg_rd_i, idle_req_i, irq_i, cpu_clk_en_o, cpu_idle_o;
  logic [cds_pkg::CDS_ADDR_W-1:0] reg_addr_i;
  logic [cds_pkg::CDS_DATA_W-1:0] reg_wdata_i, reg_rdata_o, rv;
  logic [cds_pkg::CDS_NMOD-1:0] periph_clk_en_o, mod_reg_access_o, mod_run_o;
  logic [15:0] cpu_ticks, snap;
  logic [cds_pkg::CDS_NMOD-1:0][15:0] run_ticks, rsnap;
  int num_errors = 0;
  int n_compared = 0;
  int g;
  int tab[8] = '{1, 2, 4, 8, 16, 32, 64, 256};

  cds_top dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .idle_req_i(idle_req_i),
    .irq_i(irq_i), .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .mod_reg_access_o(mod_reg_access_o), .mod_run_o(mod_run_o), .cpu_idle_o(cpu_idle_o));
  cds_cpu_model cpu_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cpu_clk_en_i(cpu_clk_en_o),
    .periph_clk_en_i(periph_clk_en_o), .mod_run_i(mod_run_o), .cpu_ticks_o(cpu_ticks), .run_ticks_o(run_ticks));

  // free-running system clock
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // one-cycle event pulse: 1 for interrupt, 0 for idle request
  task automatic ev(input bit irq);
    @(posedge ref_clk_i);
    if (irq) irq_i <= 1'b1;
    else idle_req_i <= 1'b1;
    @(posedge ref_clk_i);
    irq_i <= 1'b0;
    idle_req_i <= 1'b0;
    @(negedge ref_clk_i);
  endtask

  // cycles from one cpu enable pulse to the next, bounded
  task automatic period(output int p);
    int i;
    // callers may sit in the time step of a clock edge, so look only at settled values
    @(negedge ref_clk_i);
    for (i = 0; i < 600 && cpu_clk_en_o !== 1'b1; i++) @(negedge ref_clk_i);
    p = 0;
    do begin
      @(negedge ref_clk_i);
      p++;
    end while (cpu_clk_en_o !== 1'b1 && p < 600);
    if (i >= 600 || p >= 600) begin
      num_errors++;
      $display("CHECK FAILED at %0t: cpu clock pulse timeout", $time);
      close_out();
    end
  endtask

  initial begin
    {reg_wr_i, reg_rd_i, idle_req_i, irq_i, reg_addr_i, reg_wdata_i} = '0;
    rst_i = 1'b1;
    @(negedge ref_clk_i);
    chk({periph_clk_en_o, mod_reg_access_o, mod_run_o}, 15'h7FFC, "reset module controls");
    chk({cpu_clk_en_o, cpu_idle_o}, 2'h0, "reset cpu");
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1 chk(cpu_clk_en_o, 1'b1, "full speed after reset");
    rd(cds_pkg::CDS_ADR_CLOCK_DIVIDER_CONTROL, rv);
    chk(rv, 16'h0000, "divider reset value");
    rd(4'hF, rv);
    chk(rv, 16'h0000, "unmapped read");
    $display("test reset done");

    // every ratio; first gaps may straddle the change, the third is settled
    for (int r = 0; r < 8; r++) begin
      wr(cds_pkg::CDS_ADR_CLOCK_DIVIDER_CONTROL, {1'b0, 3'(r), 12'h800});
      repeat (3) period(g);
      chk(16'(g), 16'(tab[r]), "divided period");
      rd(cds_pkg::CDS_ADR_STATUS, rv);
      chk(rv, {5'h00, 3'(r), 8'h02}, "active ratio status");
      chk(periph_clk_en_o, 5'h1F, "peripherals full rate");
    end
    $display("test ratios done");

    wr(cds_pkg::CDS_ADR_CLOCK_DIVIDER_CONTROL, 16'h1800);
    ev(1'b1);
    rd(cds_pkg::CDS_ADR_CLOCK_DIVIDER_CONTROL, rv);
    chk(rv, 16'h1800, "interrupt without recovery");
    wr(cds_pkg::CDS_ADR_CLOCK_DIVIDER_CONTROL, 16'h9800);
    ev(1'b1);
    rd(cds_pkg::CDS_ADR_CLOCK_DIVIDER_CONTROL, rv);
    chk(rv, 16'h9000, "recovery clears enable");
    repeat (3) period(g);
    chk(16'(g), 16'h0001, "full speed after interrupt");
    $display("test interrupt done");

    wr(cds_pkg::CDS_ADR_PERIPHERAL_MODULE_DISABLE, 16'h0005);
    wr(cds_pkg::CDS_ADR_FUNCTION_ENABLE, 16'h001F);
    rd(cds_pkg::CDS_ADR_FUNCTION_ENABLE, rv);
    chk(rv, 16'h0003, "only two enable bits exist");
    @(negedge ref_clk_i);
    chk({periph_clk_en_o, mod_reg_access_o}, 10'h35A, "gated modules");
    chk(mod_run_o, 5'h1A, "enabled modules run");
    rsnap = run_ticks;
    repeat (10) @(negedge ref_clk_i);
    chk(run_ticks[0] - rsnap[0], 16'h0000, "gated module idle");
    chk(run_ticks[1] - rsnap[1], 16'h000A, "clocked module works");
    wr(cds_pkg::CDS_ADR_FUNCTION_ENABLE, 16'h0000);
    @(negedge ref_clk_i);
    chk({mod_run_o, mod_reg_access_o}, 10'h31A, "halted but accessible");
    $display("test gating done");

    wr(cds_pkg::CDS_ADR_STOP_IN_IDLE, 16'h0008);
    ev(1'b0);
    chk({cpu_idle_o, cpu_clk_en_o, mod_run_o}, 7'h50, "idle entry");
    snap = cpu_ticks;
    rsnap = run_ticks;
    repeat (10) @(negedge ref_clk_i);
    chk(cpu_ticks - snap, 16'h0000, "cpu stopped in idle");
    chk(run_ticks[4] - rsnap[4], 16'h000A, "module runs in idle");
    chk(periph_clk_en_o, 5'h1A, "system clock kept");
    rd(cds_pkg::CDS_ADR_STATUS, rv);
    chk(rv & 16'h0001, 16'h0001, "idle status");
    ev(1'b1);
    chk({cpu_idle_o, mod_run_o}, 6'h18, "wake from idle");
    $display("test idle done");

    // mid-run reset drops every setting back to its default
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(negedge ref_clk_i);
    chk({cpu_idle_o, mod_run_o, periph_clk_en_o}, 11'h39F, "controls after mid-run reset");
    rd(cds_pkg::CDS_ADR_STOP_IN_IDLE, rv);
    chk(rv, 16'h0000, "stop bits after mid-run reset");
    chk(cpu_clk_en_o, 1'h1, "full speed after mid-run reset");
    $display("test mid-run reset done");
    close_out();
  end
endmodule // testbench
